/* File: fectx_top.sv */
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fectx_map.svh"
// Behaviour
// RQ1: Mode and both codes captured only on load strobe rising edge.
// RQ2: Load aborts running sequence and starts a new one.
// RQ3: Mode 00 sends continuous ones, no codewords.
// RQ4: Mode 01 sends code A ten times, then ones.
// RQ5: Mode 10 sends A ten times, B ten times, then ones.
// RQ6: Mode 11 repeats code A until next load.
// RQ7: Code A in bits 5..0, bit 0 sent first.
// RQ8: Code B in bits 13..8, bit 8 sent first.
// RQ9: Live idle bit is 0 during codewords, 1 during ones.
// RQ10: Latched idle flag sets on live idle rising edge.
// RQ11: Latched idle flag reads one right after reset.
// RQ12: Codeword is zero, six code bits, zero, eight ones, per slot.
// RQ13: Latched flag held until cleared; interrupt while flag and enable set.

module fectx_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // AXI4-Lite write address
  input wire logic [`FECTX_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`FECTX_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Overhead insertion side
  input wire logic ovh_slot,
  output logic ovh_bit,
  // Interrupt
  output logic irq
);
  import fectx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] control_q;
  logic [15:0] values_q;
  logic [15:0] irq_en_q;
  logic idle_latched_q;
  logic load_prev_q;
  fectx_mode_t mode_q;
  logic [5:0] code_a_q;
  logic [5:0] code_b_q;
  fectx_state_t state_q;
  logic [3:0] count_q;
  logic idle_q;
  logic idle_prev_q;
  logic slot_meta_q;
  logic slot_sync_q;

  // Bus channel state
  logic aw_held_q;
  logic w_held_q;
  logic [`FECTX_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  logic wr_fire;
  logic load_event;
  logic word_done;
  logic ser_bit;
  logic ser_start;
  logic [5:0] ser_code;
  logic [15:0] rd_word;
  logic rd_hit;

  // Address decode shared by both directions
  function automatic logic [2:0] fectx_decode(input logic [`FECTX_ADDR_W-1:0] addr);
    logic [2:0] sel;
    sel = 3'h7;
    if (addr[11:10] == 2'b00 && addr[1:0] == 2'b00) begin
      case (addr[9:2])
        `FECTX_IDX_CONTROL: sel = 3'h0;
        `FECTX_IDX_VALUES: sel = 3'h1;
        `FECTX_IDX_STATUS: sel = 3'h2;
        `FECTX_IDX_LATCHED: sel = 3'h3;
        `FECTX_IDX_IRQ_EN: sel = 3'h4;
        default: sel = 3'h7;
      endcase
    end
    return sel;
  endfunction : fectx_decode

  // 16-bit register update honouring the two low byte lanes
  function automatic logic [15:0] fectx_merge(input logic [15:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : fectx_merge

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data accepted in either order
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (fectx_decode(awaddr_q) == 3'h7) ? 2'b10 : 2'b00;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-writable registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      control_q <= `FECTX_CONTROL_RESET;
      values_q <= `FECTX_VALUES_RESET;
      irq_en_q <= `FECTX_IRQ_EN_RESET;
    end else if (wr_fire) begin
      case (fectx_decode(awaddr_q))
        3'h0: control_q <= fectx_merge(control_q, wdata_q, wstrb_q) & `FECTX_CONTROL_MASK;
        3'h1: values_q <= fectx_merge(values_q, wdata_q, wstrb_q) & `FECTX_VALUES_MASK;
        3'h4: irq_en_q <= fectx_merge(irq_en_q, wdata_q, wstrb_q) & 16'h0001;
        default: ;
      endcase
    end
  end

  // Capture only on strobe rising edge; field writes alone stay inert
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      load_prev_q <= 1'b0;
    end else begin
      load_prev_q <= control_q[`FECTX_LOAD_BIT];
    end
  end
  assign load_event = control_q[`FECTX_LOAD_BIT] && !load_prev_q; // [RQ1]

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mode_q <= FECTX_MODE_IDLE;
      code_a_q <= 6'h00;
      code_b_q <= 6'h00;
    end else if (load_event) begin // [RQ1]
      mode_q <= fectx_mode_t'(control_q[`FECTX_MODE_LSB +: 2]);
      code_a_q <= values_q[`FECTX_CODE_A_LSB +: 6]; // [RQ7]
      code_b_q <= values_q[`FECTX_CODE_B_LSB +: 6]; // [RQ8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  // Slot strobe arrives from another block's timing; resynchronised
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      slot_meta_q <= 1'b0;
      slot_sync_q <= 1'b0;
    end else begin
      slot_meta_q <= ovh_slot;
      slot_sync_q <= slot_meta_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= FECTX_ST_IDLE;
      count_q <= 4'h0;
    end else if (load_event) begin // [RQ2]
      count_q <= 4'h0;
      if (control_q[`FECTX_MODE_LSB +: 2] == 2'b00) begin
        state_q <= FECTX_ST_IDLE; // [RQ3]
      end else begin
        state_q <= FECTX_ST_CODE_A;
      end
    end else if (word_done) begin
      case (state_q)
        FECTX_ST_CODE_A: begin
          if (mode_q == FECTX_MODE_CONT) begin
            count_q <= 4'h0; // [RQ6]
          end else if (count_q == `FECTX_REPEAT - 4'h1) begin
            count_q <= 4'h0;
            state_q <= (mode_q == FECTX_MODE_DUAL) ? FECTX_ST_CODE_B : FECTX_ST_IDLE; // [RQ4] [RQ5]
          end else begin
            count_q <= count_q + 4'h1;
          end
        end
        FECTX_ST_CODE_B: begin
          if (count_q == `FECTX_REPEAT - 4'h1) begin
            count_q <= 4'h0;
            state_q <= FECTX_ST_IDLE; // [RQ5]
          end else begin
            count_q <= count_q + 4'h1;
          end
        end
        default: state_q <= FECTX_ST_IDLE;
      endcase
    end
  end

  // Restart serializer on a load of mode 01, 10 or 11, or at a word boundary with another word still to send
  assign ser_start = load_event && control_q[`FECTX_MODE_LSB +: 2] != 2'b00;
  assign ser_code = (state_q == FECTX_ST_CODE_B) ? code_b_q : code_a_q;

  logic next_word;
  logic ser_kick_q;
  assign next_word = word_done && !(state_q == FECTX_ST_IDLE) &&
                     !(count_q == `FECTX_REPEAT - 4'h1 && mode_q != FECTX_MODE_CONT &&
                       (state_q == FECTX_ST_CODE_B || mode_q == FECTX_MODE_SINGLE));

  // One-cycle delay so new code values and state are in place first
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ser_kick_q <= 1'b0;
    end else begin
      ser_kick_q <= ser_start || (next_word && !load_event);
    end
  end

  fectx_serializer u_ser (
    .clock(clock),
    .rst_b(rst_b),
    .start(ser_kick_q),
    .code(ser_code),
    .slot(slot_sync_q),
    .tx_bit(ser_bit),
    .word_done(word_done)
  ); // [RQ12]

  ////////////////////////////////////////////////////////////////////////////
  // Output, status and interrupt
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ovh_bit <= 1'b1;
      idle_q <= 1'b1;
      idle_prev_q <= 1'b1;
    end else begin
      ovh_bit <= (state_q == FECTX_ST_IDLE) ? 1'b1 : ser_bit; // [RQ3]
      idle_q <= (state_q == FECTX_ST_IDLE); // [RQ9]
      idle_prev_q <= idle_q;
    end
  end

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      idle_latched_q <= 1'b1; // [RQ11]
    end else if (idle_q && !idle_prev_q) begin
      idle_latched_q <= 1'b1; // [RQ10]
    end else if (wr_fire && fectx_decode(awaddr_q) == 3'h3 && wstrb_q[0] && wdata_q[`FECTX_IDLE_BIT]) begin
      idle_latched_q <= 1'b0; // [RQ13]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= idle_latched_q && irq_en_q[`FECTX_IDLE_BIT]; // [RQ13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  always_comb begin
    rd_word = 16'h0000;
    rd_hit = 1'b1;
    case (fectx_decode(s_axi_araddr))
      3'h0: rd_word = control_q;
      3'h1: rd_word = values_q;
      3'h2: rd_word = {15'h0000, idle_q}; // [RQ9]
      3'h3: rd_word = {15'h0000, idle_latched_q};
      3'h4: rd_word = irq_en_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : fectx_top

/* File: fectx_map.svh */
`ifndef FECTX_MAP_SVH
`define FECTX_MAP_SVH

// Register indices; the byte address is four times the index
`define FECTX_IDX_CONTROL 8'hC0
`define FECTX_IDX_VALUES 8'hC2
`define FECTX_IDX_STATUS 8'hC4
`define FECTX_IDX_LATCHED 8'hC6
`define FECTX_IDX_IRQ_EN 8'hC8
`define FECTX_ADDR_W 12

// Control register fields
`define FECTX_MODE_LSB 0
`define FECTX_LOAD_BIT 2
`define FECTX_CONTROL_RESET 16'h0800
`define FECTX_CONTROL_MASK 16'hFFFF

// Code values register fields
`define FECTX_CODE_A_LSB 0
`define FECTX_CODE_B_LSB 8
`define FECTX_VALUES_RESET 16'h0000
`define FECTX_VALUES_MASK 16'h3F3F

// Status fields
`define FECTX_IDLE_BIT 0
`define FECTX_IRQ_EN_RESET 16'h0000

// Codeword shape and repetition
`define FECTX_WORD_BITS 5'd16
`define FECTX_REPEAT 4'd10
`define FECTX_SLOT_HOLD 3'd4

`endif

/* File: fectx_pkg.sv */
package fectx_pkg;
  typedef enum logic [1:0] {
    FECTX_MODE_IDLE,
    FECTX_MODE_SINGLE,
    FECTX_MODE_DUAL,
    FECTX_MODE_CONT
  } fectx_mode_t;

  typedef enum logic [1:0] {
    FECTX_ST_IDLE,
    FECTX_ST_CODE_A,
    FECTX_ST_CODE_B
  } fectx_state_t;
endpackage : fectx_pkg

/* File: fectx_serializer.sv */
`timescale 1ns/1ps
`include "fectx_map.svh"

module fectx_serializer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control
  input wire logic start,
  input wire logic [5:0] code,
  input wire logic slot,
  // Result
  output logic tx_bit,
  output logic word_done
);
  logic [15:0] shift_q;
  logic [4:0] left_q;
  logic [2:0] hold_q;
  logic [15:0] word;

  // Frame 0 c1..c6 0 then eight ones; first bit in lsb
  assign word = {8'hFF, 1'b0, code, 1'b0};

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      shift_q <= 16'hFFFF;
      left_q <= 5'h00;
      hold_q <= 3'h0;
    end else if (start) begin
      shift_q <= word;
      left_q <= `FECTX_WORD_BITS;
      hold_q <= `FECTX_SLOT_HOLD;
    end else if (hold_q != 3'h0) begin
      // Slots seen on the pin before the new bit showed carried a one
      hold_q <= hold_q - 3'h1;
    end else if (slot && left_q != 5'h00) begin
      shift_q <= {1'b1, shift_q[15:1]};
      left_q <= left_q - 5'h01;
    end
  end

  assign tx_bit = (left_q != 5'h00) ? shift_q[0] : 1'b1;
  assign word_done = slot && (left_q == 5'h01) && !start && (hold_q == 3'h0);
endmodule : fectx_serializer

/* File: fectx_top_assertions.sv */
`timescale 1ns/1ps
module fectx_top_assertions (
  // Clock and reset
  input logic clock,
  input logic rst_b,
  // Register bus
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arready,
  input logic s_axi_arvalid,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Overhead side and interrupt
  input logic ovh_slot,
  input logic ovh_bit,
  input logic irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  AST_RST_STATE: assert property (disable iff (1'b0) !rst_b |=> ovh_bit && !irq && !s_axi_bvalid)
    else $error("outputs not at reset state");
  AST_RISE_SLOT: assert property ($rose(ovh_bit) |-> $past(ovh_slot, 4) || $past(s_axi_bvalid, 2))
    else $error("code bit rose without a slot or a load");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
endmodule : fectx_top_assertions

bind fectx_top fectx_top_assertions u_ast (.clock, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .ovh_slot, .ovh_bit, .irq);

/* File: fectx_framer_model.sv */
`timescale 1ns/1ps
module fectx_framer_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Pace and captured bits
  input wire logic slow,
  output logic got_v,
  output logic got_bit,
  // Overhead side
  output logic ovh_slot,
  input wire logic ovh_bit
);
  logic [3:0] gap_q;
  always_ff @(posedge clock) begin
    if (!rst_b || gap_q == 4'h0) begin
      // Seven cycles or more between slots keeps codewords back to back
      gap_q <= slow ? 4'hA : 4'h6;
    end else begin
      gap_q <= gap_q - 4'h1;
    end
  end
  // Bit stands until the next slot, so take it as that slot is raised
  always_ff @(posedge clock) begin
    ovh_slot <= rst_b && gap_q == 4'h0;
    got_v <= rst_b && gap_q == 4'h0;
    got_bit <= ovh_bit;
  end
endmodule : fectx_framer_model

/* File: fectx_tb.sv */
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0, rst_b = 1'b0, slow = 1'b0, en = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h0001559D;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, lastb;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ovh_slot, ovh_bit, irq, got_v, got_bit;
  logic [33:0] wexp[$], rexp[$];
  logic [15:0] sr;
  logic [5:0] a, b;
  int fails = 0, tests_run = 0, cnt = 0;
  fectx_top DUT (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ovh_slot, .ovh_bit, .irq);
  fectx_framer_model u_frm (.clock, .rst_b, .slow, .got_v, .got_bit, .ovh_slot, .ovh_bit);
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [33:0] cw(input logic [5:0] c);
    return {19'h0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0, 8'hFF};
  endfunction : cw
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge clock); while (!s_axi_bvalid);
    lastb = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] ad, input logic [31:0] e, input logic [1:0] r = 2'b00);
    rexp.push_back({r, e});
    @(posedge clock);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  // Load needs a low then high strobe
  task automatic load(input logic [1:0] m);
    wr(12'h300, {30'h200, m});
    wr(12'h300, {30'h201, m});
  endtask : load
  task automatic drain();
    while (wexp.size() != 0) @(posedge clock);
    repeat (40) @(posedge clock);
  endtask : drain
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #25 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    end_sim();
  end
  always @(posedge clock) begin
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, rexp.pop_front());
  end
  // Words open on the first zero after ones; a stray word meets an impossible note
  always @(posedge clock) begin
    if (!en) begin
      cnt <= 0;
    end else if (got_v && (cnt > 0 || !got_bit)) begin
      sr <= {sr[14:0], got_bit};
      cnt <= (cnt == 15) ? 0 : cnt + 1;
      if (cnt == 15) cmp({18'h0, sr[14:0], got_bit}, wexp.size() ? wexp.pop_front() : 34'h2FFFFFFFF);
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    rd(12'h300, 32'h0800);
    rd(12'h308, 32'h0);
    rd(12'h310, 32'h1);
    rd(12'h318, 32'h1);
    rd(12'h320, 32'h0);
    rd(12'h330, 32'h0, 2'b10);
    wr(12'h330, 32'hFFFF);
    cmp(34'(lastb), 34'h2);
    $display("test reset done");
    a = 6'(xs());
    b = 6'(xs());
    wr(12'h320, 32'h1);
    wr(12'h318, 32'h1);
    rd(12'h318, 32'h0);
    wr(12'h308, {18'h0, b, 2'b00, a});
    rd(12'h310, 32'h1);
    repeat (10) wexp.push_back(cw(a));
    repeat (10) wexp.push_back(cw(b));
    load(2'b10);
    wr(12'h308, xs() & 32'h3F3F);
    rd(12'h310, 32'h0);
    drain();
    rd(12'h310, 32'h1);
    rd(12'h318, 32'h1);
    cmp(34'(irq), 34'h1);
    wr(12'h320, 32'h0);
    repeat (2) @(posedge clock);
    cmp(34'(irq), 34'h0);
    wr(12'h320, 32'h1);
    wr(12'h318, 32'h1);
    repeat (2) @(posedge clock);
    cmp(34'(irq), 34'h0);
    $display("test dual done");
    slow <= 1'b1;
    a = 6'(xs());
    wr(12'h308, {26'h0, a});
    repeat (10) wexp.push_back(cw(a));
    load(2'b01);
    drain();
    rd(12'h310, 32'h1);
    rd(12'h318, 32'h1);
    cmp(34'(irq), 34'h1);
    $display("test single done");
    slow <= 1'b0;
    repeat (12) wexp.push_back(cw(a));
    load(2'b11);
    while (wexp.size() != 0) @(posedge clock);
    en <= 1'b0;
    rd(12'h310, 32'h0);
    load(2'b00);
    repeat (60) @(posedge clock);
    en <= 1'b1;
    repeat (300) @(posedge clock);
    rd(12'h310, 32'h1);
    $display("test abort done");
    end_sim();
  end
endmodule : tb
